// [asfi_pkg.sv]
// shared constants and types for the serial channel
package asfi_pkg;

  // register byte offsets on the bus
  localparam int          ADR_W         = 5;
  localparam int          RATE_W        = 16;
  localparam logic [4:0]  OFS_CTRL      = 5'h00;
  localparam logic [4:0]  OFS_STAT      = 5'h04;
  localparam logic [4:0]  OFS_TDATA     = 5'h08;
  localparam logic [4:0]  OFS_RDATA     = 5'h0c;
  localparam logic [4:0]  OFS_RATE      = 5'h10;
  localparam logic [4:0]  OFS_IRQ_STAT  = 5'h14;
  localparam logic [4:0]  OFS_IRQ_MASK  = 5'h18;

  // serial_control_reg field positions
  localparam int          CTL_TXE_IE    = 7;
  localparam int          CTL_RX_IE     = 6;
  localparam int          CTL_TX_EN     = 5;
  localparam int          CTL_RX_EN     = 4;
  localparam int          CTL_TEND_IE   = 2;
  localparam logic [7:0]  CTRL_MASK     = 8'hf4;

  // serial_status_reg field positions
  localparam int          ST_TRANSMIT_EMPTY_FLAG       = 7;
  localparam int          ST_RECEIVE_FULL_FLAG       = 6;
  localparam int          ST_OVERRUN_ERROR_FLAG       = 5;
  localparam int          ST_FER        = 4;
  localparam int          ST_TEND       = 2;

  // interrupt status and mask bit positions
  localparam int          IRQ_N         = 4;
  localparam int          IRQ_RXF       = 0;
  localparam int          IRQ_ERR       = 1;
  localparam int          IRQ_TXE       = 2;
  localparam int          IRQ_TEND      = 3;

  // reset values
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam logic [7:0]  STAT_RESET    = 8'h84;
  localparam logic [15:0] RATE_RESET    = 16'h01b2;

  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} asfi_rx_state_t;
  typedef enum {TX_IDLE, TX_START, TX_DATA, TX_STOP} asfi_tx_state_t;

  // clocks per bit, never below one
  function automatic logic [RATE_W-1:0] asfi_period(
    input logic [RATE_W-1:0] rate);
    asfi_period = (rate == '0) ? RATE_W'(1) : rate;
  endfunction : asfi_period

endpackage : asfi_pkg

// [asfi_link_if.sv]
// signals between the register core and the two shifters
`timescale 1ns/1ns
interface asfi_link_if;
  logic [15:0] rate;
  logic        rx_line;
  logic        rx_enable;
  logic        rx_done;
  logic        rx_frame_err;
  logic [7:0]  rx_byte;
  logic        tx_enable;
  logic        tx_have;
  logic [7:0]  tx_byte;
  logic        tx_take;
  logic        tx_idle;
  logic        tx_line;

  modport rx_side (input rate, rx_line, rx_enable,
                   output rx_done, rx_frame_err, rx_byte);
  modport tx_side (input rate, tx_enable, tx_have, tx_byte,
                   output tx_take, tx_idle, tx_line);
endinterface : asfi_link_if

// [asfi_rx.sv]
// receive shifter: start detect, mid-bit sampling, stop check
`timescale 1ns/1ns
module asfi_rx (
  input  wire logic     clk_in,
  input  wire logic     reset_in,
  asfi_link_if.rx_side  link
);
  import asfi_pkg::*;

  asfi_rx_state_t    state;
  logic [RATE_W-1:0] cnt;
  logic [2:0]        bit_idx;
  logic [7:0]        shift;
  wire  [RATE_W-1:0] period = asfi_period(link.rate);
  wire               tick   = (cnt == '0);

  // frame sequencer; disable drops any frame in progress
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state             <= RX_IDLE;
      cnt               <= '0;
      bit_idx           <= '0;
      shift             <= '0;
      link.rx_done      <= 1'b0;
      link.rx_frame_err <= 1'b0;
      link.rx_byte      <= '0;
    end else begin
      link.rx_done      <= 1'b0;
      if (!tick) cnt    <= cnt - 1'b1;
      if (!link.rx_enable) begin
        state <= RX_IDLE;
      end else begin
        unique case (state)
          RX_IDLE: if (!link.rx_line) begin
            state <= RX_START;
            cnt   <= period >> 1;  // aim at mid-bit
          end
          RX_START: if (tick) begin
            state   <= link.rx_line ? RX_IDLE : RX_DATA;  // glitch filter
            cnt     <= period - 1'b1;
            bit_idx <= '0;
          end
          RX_DATA: if (tick) begin
            shift   <= {link.rx_line, shift[7:1]};  // lsb first
            cnt     <= period - 1'b1;
            bit_idx <= bit_idx + 1'b1;
            if (bit_idx == 3'h7) state <= RX_STOP;
          end
          RX_STOP: if (tick) begin
            state             <= RX_IDLE;
            link.rx_done      <= 1'b1;
            link.rx_frame_err <= !link.rx_line;
            link.rx_byte      <= shift;
          end
        endcase
      end
    end
  end

  AST_RX_START: assert property (@(posedge clk_in) disable iff (reset_in)
    (state == RX_IDLE && link.rx_enable && !link.rx_line)
      |=> state == RX_START)
    else $error("start bit not taken");

endmodule : asfi_rx

// [asfi_tx.sv]
// transmit shifter: start, eight data bits lsb first, one stop
`timescale 1ns/1ns
module asfi_tx (
  input  wire logic     clk_in,
  input  wire logic     reset_in,
  asfi_link_if.tx_side  link
);
  import asfi_pkg::*;

  asfi_tx_state_t    state;
  logic [RATE_W-1:0] cnt;
  logic [2:0]        bit_idx;
  logic [7:0]        shift;
  wire  [RATE_W-1:0] period = asfi_period(link.rate);
  wire               tick   = (cnt == '0);

  // handshake back to the core is combinational
  assign link.tx_idle = (state == TX_IDLE);
  assign link.tx_take = link.tx_idle && link.tx_enable && link.tx_have;

  // line idles high, also while disabled
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state        <= TX_IDLE;
      cnt          <= '0;
      bit_idx      <= '0;
      shift        <= '0;
      link.tx_line <= 1'b1;
    end else if (!link.tx_enable) begin
      state        <= TX_IDLE;
      link.tx_line <= 1'b1;
    end else begin
      if (!tick) cnt <= cnt - 1'b1;
      unique case (state)
        TX_IDLE: if (link.tx_take) begin
          shift        <= link.tx_byte;
          link.tx_line <= 1'b0;
          cnt          <= period - 1'b1;
          state        <= TX_START;
        end
        TX_START: if (tick) begin
          link.tx_line <= shift[0];
          shift        <= shift >> 1;
          bit_idx      <= '0;
          cnt          <= period - 1'b1;
          state        <= TX_DATA;
        end
        TX_DATA: if (tick) begin
          link.tx_line <= (bit_idx == 3'h7) ? 1'b1 : shift[0];
          shift        <= shift >> 1;
          bit_idx      <= bit_idx + 1'b1;
          cnt          <= period - 1'b1;
          if (bit_idx == 3'h7) state <= TX_STOP;
        end
        TX_STOP: if (tick) state <= TX_IDLE;
      endcase
    end
  end

endmodule : asfi_tx

// [asfi_top.sv]
// serial channel core: wishbone registers, flags and interrupts
`timescale 1ns/1ns

// Summary of operation
// - start bit starts receiving when enabled
// - full byte: buffer, full flag, receive request
// - overrun sets error flag and error request
// - error flag clears by zero after read
// - all errors cleared re-enables reception
// - error request drops once errors cleared
// - clearing end enable withdraws end request
module asfi_top (
  input  wire logic                      clk_in,
  input  wire logic                      reset_in,
  input  wire logic                      wb_cyc_in,
  input  wire logic                      wb_stb_in,
  input  wire logic                      wb_we_in,
  input  wire logic [asfi_pkg::ADR_W-1:0] wb_adr_in,
  input  wire logic [3:0]                wb_sel_in,
  input  wire logic [31:0]               wb_dat_in,
  output logic      [31:0]               wb_dat_out,
  output logic                           wb_ack_out,
  input  wire logic                      rx_data_in,
  output logic                           tx_data_out,
  output logic                           irq_out,
  output logic                           receive_full_request_out,
  output logic                           receive_error_request_out,
  output logic                           transmit_empty_request_out,
  output logic                           transmit_end_request_out
);
  import asfi_pkg::*;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  asfi_link_if link ();

  logic [7:0]        serial_control_reg;
  logic [7:0]        serial_status_reg;
  logic [7:0]        transmit_data_reg;
  logic [7:0]        receive_data_reg;
  logic [RATE_W-1:0] bit_rate_reg;
  logic [IRQ_N-1:0]  irq_stat;
  logic [IRQ_N-1:0]  irq_mask;
  logic [IRQ_N-1:0]  req_q;
  logic              armed_overrun_error_flag;
  logic              armed_fer;
  logic [1:0]        rx_sync;
  logic [7:0]        next_stat;

  // bus decode: reads sampled before ack, writes land on the ack edge
  wire        bus_req  = wb_cyc_in && wb_stb_in;
  wire        rd_take  = bus_req && !wb_we_in && !wb_ack_out;
  wire        wr_now   = bus_req && wb_we_in && wb_ack_out && wb_sel_in[0];
  wire        hit_ctrl = (wb_adr_in == OFS_CTRL);
  wire        hit_stat = (wb_adr_in == OFS_STAT);
  wire        hit_tdat = (wb_adr_in == OFS_TDATA);
  wire        hit_rdat = (wb_adr_in == OFS_RDATA);
  wire        hit_rate = (wb_adr_in == OFS_RATE);
  wire        hit_irqs = (wb_adr_in == OFS_IRQ_STAT);
  wire        hit_irqm = (wb_adr_in == OFS_IRQ_MASK);
  wire [7:0]  wdat     = wb_dat_in[7:0];
  wire        wr_stat  = wr_now && hit_stat;
  wire        rd_stat  = rd_take && hit_stat;
  wire        rd_irqs  = rd_take && hit_irqs;

  // read mux, unmapped offsets read zero
  wire [31:0] rd_word =
    hit_ctrl ? {24'h0, serial_control_reg} :
    hit_stat ? {24'h0, serial_status_reg}  :
    hit_tdat ? {24'h0, transmit_data_reg}  :
    hit_rdat ? {24'h0, receive_data_reg}   :
    hit_rate ? {16'h0, bit_rate_reg}       :
    hit_irqs ? {28'h0, irq_stat}           :
    hit_irqm ? {28'h0, irq_mask}           : 32'h0;

  // flag and event decode
  wire err_any  = serial_status_reg[ST_OVERRUN_ERROR_FLAG] || serial_status_reg[ST_FER];
  wire byte_in  = link.rx_done;
  wire overrun  = byte_in && serial_status_reg[ST_RECEIVE_FULL_FLAG];
  wire byte_ok  = byte_in && !serial_status_reg[ST_RECEIVE_FULL_FLAG];
  wire rx_ie    = serial_control_reg[CTL_RX_IE];

  // receiver runs only while no error pends
  assign link.rx_enable = serial_control_reg[CTL_RX_EN] && !err_any;
  assign link.rx_line   = rx_sync[1];
  assign link.rate      = bit_rate_reg;
  assign link.tx_enable = serial_control_reg[CTL_TX_EN];
  assign link.tx_have   = !serial_status_reg[ST_TRANSMIT_EMPTY_FLAG];
  assign link.tx_byte   = transmit_data_reg;
  assign tx_data_out    = link.tx_line;

  // request lines follow the flags, no latching
  // full flag drives receive request
  assign receive_full_request_out  = rx_ie && serial_status_reg[ST_RECEIVE_FULL_FLAG];
  // error request is the live error flags
  assign receive_error_request_out = rx_ie && err_any;
  assign transmit_empty_request_out =
    serial_control_reg[CTL_TXE_IE] && serial_control_reg[CTL_TX_EN] &&
    serial_status_reg[ST_TRANSMIT_EMPTY_FLAG];
  // end request gated by its enable
  assign transmit_end_request_out =
    serial_control_reg[CTL_TEND_IE] && serial_status_reg[ST_TEND];

  wire [IRQ_N-1:0] req_now = {transmit_end_request_out,
                              transmit_empty_request_out,
                              receive_error_request_out,
                              receive_full_request_out};
  wire [IRQ_N-1:0] irq_set = req_now & ~req_q;
  wire [IRQ_N-1:0] irq_clr = rd_irqs ? irq_stat : '0;
  assign irq_out = |(irq_stat & irq_mask);

  // status next value: software clears first, hardware sets win
  always_comb begin
    next_stat = serial_status_reg;
    if (wr_stat) begin
      if (!wdat[ST_RECEIVE_FULL_FLAG]) next_stat[ST_RECEIVE_FULL_FLAG] = 1'b0;
      if (!wdat[ST_TRANSMIT_EMPTY_FLAG]) begin
        next_stat[ST_TRANSMIT_EMPTY_FLAG] = 1'b0;
        next_stat[ST_TEND] = 1'b0;
      end
      // zero clears only after a read saw it set
      if (!wdat[ST_OVERRUN_ERROR_FLAG] && armed_overrun_error_flag) next_stat[ST_OVERRUN_ERROR_FLAG] = 1'b0;
      if (!wdat[ST_FER] && armed_fer) next_stat[ST_FER] = 1'b0;
    end
    if (byte_ok) begin
      next_stat[ST_RECEIVE_FULL_FLAG] = 1'b1;
      if (link.rx_frame_err) next_stat[ST_FER] = 1'b1;
    end
    if (overrun) next_stat[ST_OVERRUN_ERROR_FLAG] = 1'b1;
    if (link.tx_take) next_stat[ST_TRANSMIT_EMPTY_FLAG] = 1'b1;
    // a byte taken this cycle leaves the shifter busy: no early end flag
    if (link.tx_idle && !link.tx_take && next_stat[ST_TRANSMIT_EMPTY_FLAG])
      next_stat[ST_TEND] = 1'b1;
  end

  // pin synchroniser, second stage is the only reader of the first
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) rx_sync <= 2'b11;
    else rx_sync <= {rx_sync[0], rx_data_in};
  end

  // bus handshake and read data, one wait state
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= '0;
    end else begin
      wb_ack_out <= bus_req && !wb_ack_out;
      if (rd_take) wb_dat_out <= rd_word;
    end
  end

  // control, rate, mask and transmit data writes
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      serial_control_reg <= CTRL_RESET;
      bit_rate_reg       <= RATE_RESET;
      irq_mask           <= '0;
      transmit_data_reg  <= '0;
    end else if (wr_now) begin
      // unused bits read back as zero for polling
      if (hit_ctrl) serial_control_reg <= wdat & CTRL_MASK;
      if (hit_rate) bit_rate_reg <= wb_dat_in[RATE_W-1:0];
      if (hit_irqm) irq_mask <= wdat[IRQ_N-1:0];
      if (hit_tdat) transmit_data_reg <= wdat;
    end
  end

  // status flags; arming tracks a read that saw an error set
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      serial_status_reg <= STAT_RESET;
      armed_overrun_error_flag        <= 1'b0;
      armed_fer         <= 1'b0;
    end else begin
      serial_status_reg <= next_stat;
      if (rd_stat) begin
        armed_overrun_error_flag <= serial_status_reg[ST_OVERRUN_ERROR_FLAG];
        armed_fer  <= serial_status_reg[ST_FER];
      end else if (wr_stat) begin
        armed_overrun_error_flag <= 1'b0;
        armed_fer  <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) receive_data_reg <= '0;
    else if (byte_ok) receive_data_reg <= link.rx_byte;
  end

  // sticky interrupt status, a read clears what it returned
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      irq_stat <= '0;
      req_q    <= '0;
    end else begin
      req_q    <= req_now;
      irq_stat <= (irq_stat & ~irq_clr) | irq_set;  // set wins
    end
  end

  asfi_rx u_rx (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .link     (link.rx_side)
  );

  asfi_tx u_tx (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .link     (link.tx_side)
  );

  // full flag and buffer follow a good byte
  AST_RX_FULL: assert property (
    byte_ok |=> serial_status_reg[ST_RECEIVE_FULL_FLAG] &&
      receive_data_reg == $past(link.rx_byte))
    else $error("byte not moved to buffer");

  // overrun raises error flag and request
  AST_OVERRUN: assert property (
    (overrun && rx_ie && serial_control_reg == $past(serial_control_reg))
      |=> serial_status_reg[ST_OVERRUN_ERROR_FLAG] ##0 receive_error_request_out)
    else $error("overrun not reported");

  // no clear without a prior read
  AST_ERR_CLEAR: assert property (
    (serial_status_reg[ST_OVERRUN_ERROR_FLAG] && !armed_overrun_error_flag) |=>
      serial_status_reg[ST_OVERRUN_ERROR_FLAG])
    else $error("overrun flag cleared without read");

  AST_ERR_WRITE: assert property (
    (wr_stat && !wdat[ST_OVERRUN_ERROR_FLAG] && armed_overrun_error_flag && !overrun) |=>
      !serial_status_reg[ST_OVERRUN_ERROR_FLAG])
    else $error("armed clear ignored");

  // receiver resumes after last error clears
  AST_RX_RESUME: assert property (
    ($fell(serial_status_reg[ST_OVERRUN_ERROR_FLAG]) && !serial_status_reg[ST_FER] &&
     serial_control_reg[CTL_RX_EN]) |-> link.rx_enable)
    else $error("receiver not re-enabled");

  // error request gone with the flags
  AST_ERR_REQ_DROP: assert property (
    ($past(receive_error_request_out) && !err_any) |->
      !receive_error_request_out)
    else $error("error request stuck");

  // end request withdrawn on enable clear
  AST_TEND_WITHDRAW: assert property (
    $fell(serial_control_reg[CTL_TEND_IE]) |->
      !transmit_end_request_out)
    else $error("end request not withdrawn");

  AST_KEEP_BUF: assert property (
    overrun |=> $stable(receive_data_reg) [*2])
    else $error("buffer overwritten on overrun");

  // bus ack lasts exactly one cycle
  AST_WB_ACK: assert property (
    wb_ack_out |=> !wb_ack_out)
    else $error("ack held too long");

  // bus answer after exactly one wait state
  AST_WB_ANSWER: assert property (
    (bus_req && !wb_ack_out) |=> wb_ack_out)
    else $error("ack not given after one wait state");

  // full flag only from a completed byte
  AST_RXF_SET: assert property (
    $rose(serial_status_reg[ST_RECEIVE_FULL_FLAG]) |-> $past(byte_ok))
    else $error("full flag set without a byte");

  // no byte completes while an error pends
  AST_RX_HALT: assert property (
    err_any |=> !link.rx_done)
    else $error("receiver ran with an error pending");

  // sticky status keeps every bit that a request edge set
  AST_IRQ_STICKY: assert property (
    (irq_set != '0) |=> (irq_stat & $past(irq_set)) == $past(irq_set))
    else $error("interrupt status bit lost");

  // end flag rises only once the shifter has nothing left to send
  AST_TEND_SET: assert property (
    $rose(serial_status_reg[ST_TEND]) |->
      $past(link.tx_idle && !link.tx_take))
    else $error("end flag set while a byte is pending");

endmodule : asfi_top

// [asfi_serial_peer.sv]
// remote serial device model: 8n1 frames to and from the channel
`timescale 1ns/1ns
module asfi_serial_peer #(
  parameter int BIT_CLKS = 8
) (
  input  wire logic clk_in,
  input  wire logic line_in,
  output logic      line_out
);
  logic [7:0] got_q[$];
  logic [7:0] shift;
  int         i;

  // line idles high, so a stray low is never seen as a start
  initial line_out = 1'b1;

  // one frame, lsb first, each bit held a whole bit period
  task automatic send_byte(input logic [7:0] data);
    logic [9:0] frame;
    frame = {1'b1, data, 1'b0};
    for (int b = 0; b < 10; b++) begin
      @(posedge clk_in);
      line_out <= frame[b];
      repeat (BIT_CLKS - 1) @(posedge clk_in);
    end
  endtask : send_byte

  // mid-bit sampling; a frame with a bad stop is dropped
  always begin
    @(posedge clk_in);
    if (line_in === 1'b0) begin
      repeat (BIT_CLKS / 2) @(posedge clk_in);
      for (i = 0; i < 8; i++) begin
        repeat (BIT_CLKS) @(posedge clk_in);
        shift[i] = line_in;
      end
      repeat (BIT_CLKS) @(posedge clk_in);
      if (line_in === 1'b1) got_q.push_back(shift);
    end
  end
endmodule : asfi_serial_peer

// [tb_top.sv]
// self-checking bench for the serial channel flags and interrupts
`timescale 1ns/1ns
module tb_top;
  import asfi_pkg::*;
  localparam int BITC = 8;
  logic             clk_in;
  logic             reset_in;
  logic             wb_cyc;
  logic             wb_stb;
  logic             wb_we;
  logic [ADR_W-1:0] wb_adr;
  logic [3:0]       wb_sel;
  logic [31:0]      wb_wdat;
  logic [31:0]      wb_rdat;
  logic [31:0]      rd;
  logic             wb_ack;
  logic             rx_line;
  logic             tx_line;
  logic             irq;
  logic             rxf_req;
  logic             err_req;
  logic             txe_req;
  logic             tend_req;
  wire  [4:0]       reqs = {irq, tend_req, txe_req, err_req, rxf_req};
  int               num_errors;
  int               checked;

  asfi_top dut_u (
    .clk_in(clk_in), .reset_in(reset_in), .wb_cyc_in(wb_cyc),
    .wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_adr_in(wb_adr),
    .wb_sel_in(wb_sel), .wb_dat_in(wb_wdat), .wb_dat_out(wb_rdat),
    .wb_ack_out(wb_ack), .rx_data_in(rx_line), .tx_data_out(tx_line),
    .irq_out(irq), .receive_full_request_out(rxf_req),
    .receive_error_request_out(err_req),
    .transmit_empty_request_out(txe_req),
    .transmit_end_request_out(tend_req)
  );

  asfi_serial_peer #(.BIT_CLKS(BITC)) peer_u (
    .clk_in(clk_in), .line_in(tx_line), .line_out(rx_line)
  );

  // free-running 50 MHz clock
  always #10 clk_in = ~clk_in;

  task automatic stop_test;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // classic cycle: hold until ack, release, leave cyc low a cycle
  task automatic wb_io(input logic we, input logic [4:0] adr,
                       input logic [31:0] wdat, output logic [31:0] rdat);
    int n;
    n = 0;
    @(posedge clk_in);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= we;
    wb_adr  <= adr;
    wb_wdat <= wdat;
    do begin
      @(posedge clk_in);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    rdat = wb_rdat;
    chk({31'h0, wb_ack}, 32'h1, "bus ack");
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
    @(negedge clk_in);
  endtask : wb_io

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    wb_io(1'b1, a, d, rd);
  endtask : wr

  task automatic rdc(input logic [4:0] a, input logic [31:0] e,
                     input string m);
    wb_io(1'b0, a, 32'h0, rd);
    chk(rd, e, m);
  endtask : rdc

  // bounded wait, a frame is well under the limit
  task automatic wait_req(input int idx, input string m);
    int n;
    n = 0;
    while (reqs[idx] !== 1'b1 && n < 3000) begin
      @(negedge clk_in);
      n++;
    end
    // sticky status and irq lag the request line by one edge
    @(negedge clk_in);
    chk({31'h0, reqs[idx]}, 32'h1, m);
  endtask : wait_req

  task automatic test_reset_regs;
    logic [4:0]  adr [6] = '{OFS_CTRL, OFS_STAT, OFS_RATE, OFS_IRQ_MASK,
                             OFS_IRQ_STAT, 5'h1c};
    logic [31:0] exp [6] = '{32'(CTRL_RESET), 32'(STAT_RESET),
                             32'(RATE_RESET), 32'h0, 32'h0, 32'h0};
    chk({31'h0, tx_line}, 32'h1, "tx idle");
    foreach (adr[k]) rdc(adr[k], exp[k], "reset value");
    wr(5'h1c, 32'hff);
    rdc(5'h1c, 32'h0, "unmapped");
    wr(OFS_RATE, 32'(BITC));
    rdc(OFS_RATE, 32'(BITC), "rate");
    repeat (BITC) @(posedge clk_in);
  endtask : test_reset_regs

  task automatic test_receive;
    wr(OFS_IRQ_MASK, 32'h03);
    wr(OFS_CTRL, 32'h50);
    chk({31'h0, irq}, 32'h0, "irq idle");
    peer_u.send_byte(8'ha5);
    wait_req(0, "full request");
    chk({31'h0, irq}, 32'h1, "irq raised");
    rdc(OFS_STAT, 32'hc4, "full flag");
    rdc(OFS_RDATA, 32'ha5, "rx data");
    rdc(OFS_IRQ_STAT, 32'h01, "irq status");
    chk({31'h0, irq}, 32'h0, "irq cleared by read");
    wr(OFS_STAT, 32'hbf);
    chk({31'h0, rxf_req}, 32'h0, "full request drop");
    rdc(OFS_STAT, 32'h84, "full cleared");
  endtask : test_receive

  task automatic test_overrun;
    peer_u.send_byte(8'h11);
    peer_u.send_byte(8'h22);
    wait_req(1, "error request");
    chk({31'h0, irq}, 32'h1, "error irq");
    rdc(OFS_RDATA, 32'h11, "buffer kept");
    wr(OFS_STAT, 32'hdf);
    chk({31'h0, err_req}, 32'h1, "clear without read");
    rdc(OFS_STAT, 32'he4, "overrun flag");
    wr(OFS_STAT, 32'hdf);
    chk({31'h0, err_req}, 32'h0, "error request drop");
    wr(OFS_STAT, 32'hbf);
    peer_u.send_byte(8'h5a);
    wait_req(0, "receive after errors");
    rdc(OFS_RDATA, 32'h5a, "rx data again");
    wr(OFS_STAT, 32'hbf);
  endtask : test_overrun

  task automatic test_transmit;
    logic [7:0] bytes [2] = '{8'h3c, 8'hc3};
    wb_io(1'b0, OFS_IRQ_STAT, 32'h0, rd);
    wr(OFS_CTRL, 32'ha0);
    wait_req(2, "empty request");
    chk({31'h0, irq}, 32'h0, "masked irq");
    rdc(OFS_IRQ_STAT, 32'h04, "empty latched");
    // back to back bytes through the double buffer
    foreach (bytes[k]) begin
      wait_req(2, "empty request");
      wb_io(1'b0, OFS_STAT, 32'h0, rd);
      chk(rd & 32'h80, 32'h80, "empty flag");
      wr(OFS_TDATA, {24'h0, bytes[k]});
      wr(OFS_STAT, 32'h7f);
    end
    wr(OFS_CTRL, 32'h24);
    wait_req(3, "end request");
    chk(32'(peer_u.got_q.size()), 32'h2, "frames sent");
    foreach (bytes[k]) chk({24'h0, peer_u.got_q[k]}, {24'h0, bytes[k]}, "tx");
    wb_io(1'b0, OFS_CTRL, 32'h0, rd);
    wr(OFS_CTRL, rd & 32'h0b);
    chk({31'h0, tend_req}, 32'h0, "end request withdrawn");
    wb_io(1'b0, OFS_CTRL, 32'h0, rd);
    chk(rd & 32'hf4, 32'h0, "control cleared");
  endtask : test_transmit

  // watchdog: the whole run needs under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk_in);
    num_errors++;
    $display("ERROR at %0t: timeout", $time);
    stop_test();
  end

  initial begin
    clk_in     = 1'b0;
    reset_in   = 1'b1;
    wb_cyc     = 1'b0;
    wb_stb     = 1'b0;
    wb_we      = 1'b0;
    wb_adr     = '0;
    wb_sel     = 4'hf;
    wb_wdat    = '0;
    num_errors = 0;
    checked    = 0;
    repeat (5) @(posedge clk_in);
    reset_in <= 1'b0;
    @(negedge clk_in);
    test_reset_regs();
    test_receive();
    test_overrun();
    test_transmit();
    stop_test();
  end
endmodule : tb_top
